//--- hw/bit_sync.sv
// two-stage synchroniser for the pins and the write toggle
`timescale 1ns/100ps
`default_nettype none
module bit_sync
    import tof_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            ce,
    input  wire logic [SY_W-1:0] async_in,
    output var  logic [SY_W-1:0] sync_out
);
    typedef struct packed {
        logic [SY_W-1:0] meta;
        logic [SY_W-1:0] held;
    } sync_s;

    sync_s q;
    sync_s d;

    // first stage feeds only the second
    always_comb begin
        d.meta = async_in;
        d.held = q.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= {SYNC_RST, SYNC_RST};
        end else if (ce) begin
            q <= d;
        end
    end

    assign sync_out = q.held;
endmodule : bit_sync
`default_nettype wire

//--- hw/spi_link.sv
// serial register port on the shift clock
`timescale 1ns/100ps
`default_nettype none
module spi_link
    import tof_pkg::*;
(
    input  wire logic  sclk,
    input  wire logic  select_n,
    input  wire logic  sdi,
    output var  logic  sdo,
    output var  logic  sdo_oe_n,
    reg_link_if.link   lk
);
    typedef struct packed {
        logic [6:0]  shin;
        logic [4:0]  cnt;
        logic        cmd_ok;
        logic        auto_inc;
        logic        write;
        logic        halted;
        logic [5:0]  addr;
        logic [23:0] shout;
        logic        reading;
        logic [5:0]  wr_addr;
        logic [7:0]  wr_data;
        logic        wr_tgl;
    } link_s;

    link_s      q;
    link_s      d;
    logic [7:0] byte_in;

    // bank is frozen by the core while select is low, so it is stable here
    function automatic logic [23:0] rd_word(input logic [5:0] a);
        if (a >= 6'(REG_NUM)) begin
            return 24'h000000;
        end
        if (reg_len(a) == 5'(WORD_BITS)) begin
            return lk.rd_bank[a[4:0]];
        end
        return {lk.rd_bank[a[4:0]][7:0], 16'h0000};
    endfunction : rd_word

    always_comb begin
        byte_in = {q.shin, sdi};
        d       = q;
        d.shin  = byte_in[6:0];
        if (!q.cmd_ok) begin
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == 5'(BYTE_BITS - 1)) begin
                d.cmd_ok   = 1'b1;
                d.cnt      = 5'h00;
                d.auto_inc = byte_in[CMD_AUTO];
                d.write    = byte_in[CMD_WRITE];
                d.addr     = byte_in[5:0];
                d.reading  = ~byte_in[CMD_WRITE];
                d.shout    = rd_word(byte_in[5:0]);
            end
        end else if (!q.halted) begin
            d.cnt   = q.cnt + 5'h01;
            d.shout = {q.shout[22:0], 1'b0};
            if (q.write && q.cnt == 5'(BYTE_BITS - 1) && q.addr <= A_ECHO_BLANK_L) begin
                d.wr_addr = q.addr;
                d.wr_data = byte_in;
                d.wr_tgl  = ~q.wr_tgl;
            end
            if (q.cnt == reg_len(q.addr) - 5'h01) begin
                d.cnt = 5'h00;
                if (q.auto_inc) begin
                    d.addr  = q.addr + 6'h01;
                    d.shout = rd_word(q.addr + 6'h01);
                end else begin
                    d.halted = 1'b1;
                end
            end
        end
    end

    // select high clears the whole port, aborting any partial frame
    always_ff @(posedge sclk or posedge select_n) begin
        if (select_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sdo      = q.shout[23];
    assign sdo_oe_n = ~q.reading;
    assign lk.wr_addr = q.wr_addr;
    assign lk.wr_data = q.wr_data;
    assign lk.wr_tgl  = q.wr_tgl;
endmodule : spi_link
`default_nettype wire

//--- hw/tof_measurement_sequencer.sv
// measurement sequencer core with its serial register port
`timescale 1ns/100ps
`default_nettype none
module tof_measurement_sequencer
    import tof_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        enable,
    input  wire logic        sclk,
    input  wire logic        select_n,
    input  wire logic        sdi,
    output var  logic        sdo,
    output var  logic        sdo_oe_n,
    input  wire logic        start_in,
    input  wire logic        stop_in,
    input  wire logic [23:0] fine_code,
    output var  logic        fire_out,
    output var  logic        done_irq_n
);
    typedef struct packed {
        reg_bank_t   regs;
        reg_bank_t   bank;
        seq_state_e  st;
        logic [15:0] cnt;
        logic [2:0]  stop_idx;
        logic [7:0]  avg_idx;
        logic [5:0]  cal_cnt;
        logic        ovf_hit;
        logic        start_prev;
        logic        stop_prev;
        logic        tgl_prev;
        logic        fire;
        logic        fire_pin;
        logic        irq_n;
    } core_s;

    core_s           q;
    core_s           n;
    logic [SY_W-1:0] sync_in;
    logic [SY_W-1:0] sy;
    logic            rst_all;
    logic [7:0]      setup1;
    logic [7:0]      setup2;
    logic            mode2;
    logic [15:0]     limit;
    logic [15:0]     blank;
    logic [2:0]      stops;
    logic [7:0]      avg_total;
    logic [5:0]      cal_len;
    logic            start_hit;
    logic            stop_hit;
    logic [4:0]      time_idx;
    logic [4:0]      tally_idx;
    logic [7:0]      set_fl;
    logic [7:0]      clr_fl;
    logic [7:0]      flags;

    reg_link_if bus ();

    function automatic core_s core_reset();
        core_s r;
        r = '0;
        r.regs[A_SECOND_SETUP[4:0]]   = {16'h0000, RST_SECOND_SETUP};
        r.regs[A_EVENT_ENABLE[4:0]]   = {16'h0000, RST_EVENT_ENABLE};
        r.regs[A_COARSE_LIMIT_H[4:0]] = {16'h0000, RST_LIMIT};
        r.regs[A_COARSE_LIMIT_L[4:0]] = {16'h0000, RST_LIMIT};
        r.regs[A_TICK_LIMIT_H[4:0]]   = {16'h0000, RST_LIMIT};
        r.regs[A_TICK_LIMIT_L[4:0]]   = {16'h0000, RST_LIMIT};
        r.bank  = r.regs;
        r.st    = S_IDLE;
        r.irq_n = 1'b1;
        return r;
    endfunction : core_reset

    always_comb begin
        sync_in           = '0;
        sync_in[SY_EN]    = enable;
        sync_in[SY_START] = start_in;
        sync_in[SY_STOP]  = stop_in;
        sync_in[SY_SEL]   = select_n;
        sync_in[SY_TGL]   = bus.wr_tgl;
    end

    bit_sync u_sync (
        .clk      (ref_clk),
        .rst      (rst),
        .ce       (ce),
        .async_in (sync_in),
        .sync_out (sy)
    );

    spi_link u_spi (
        .sclk     (sclk),
        .select_n (select_n),
        .sdi      (sdi),
        .sdo      (sdo),
        .sdo_oe_n (sdo_oe_n),
        .lk       (bus.link)
    );

    // enable low holds every setting at its default
    assign rst_all = rst | ~sy[SY_EN];

    always_comb begin
        n      = q;
        set_fl = 8'h00;
        clr_fl = 8'h00;
        setup1 = q.regs[A_FIRST_SETUP[4:0]][7:0];
        setup2 = q.regs[A_SECOND_SETUP[4:0]][7:0];
        mode2  = setup1[B_MODE +: 2] == MODE_SECOND;
        if (mode2) begin
            limit = {q.regs[A_TICK_LIMIT_H[4:0]][7:0], q.regs[A_TICK_LIMIT_L[4:0]][7:0]};
        end else begin
            limit = {q.regs[A_COARSE_LIMIT_H[4:0]][7:0], q.regs[A_COARSE_LIMIT_L[4:0]][7:0]};
        end
        blank = {q.regs[A_ECHO_BLANK_H[4:0]][7:0], q.regs[A_ECHO_BLANK_L[4:0]][7:0]};
        // out-of-range stop codes fall back to a single stop
        if (setup2[B_STOPS +: 3] < MAX_STOPS) begin
            stops = setup2[B_STOPS +: 3] + 3'h1;
        end else begin
            stops = 3'h1;
        end
        avg_total = 8'h01 << setup2[B_AVG +: 3];
        cal_len   = CAL_PERIODS[setup2[B_CALP +: 2]];
        start_hit = edge_hit(q.start_prev, sy[SY_START], setup1[B_START_FALL]);
        stop_hit  = edge_hit(q.stop_prev, sy[SY_STOP], setup1[B_STOP_FALL]);
        time_idx  = 5'(A_INTERVAL_FIRST) + {1'b0, q.stop_idx, 1'b0} + 5'h02;
        tally_idx = 5'(A_CYCLE_TALLY) + {1'b0, q.stop_idx, 1'b0};
        n.start_prev = sy[SY_START];
        n.stop_prev  = sy[SY_STOP];

        case (q.st)
            S_IDLE: begin
                if (setup1[B_GO]) begin
                    n.st      = S_ARM;
                    n.fire    = 1'b1;
                    n.avg_idx = 8'h00;
                    // tallies accumulate over a series, so clear them first
                    for (int i = int'(A_INTERVAL_FIRST); i < REG_NUM; i++) begin
                        n.regs[i] = 24'h000000;
                    end
                end
            end
            S_ARM: begin
                // no timeout here: a missing start is waited for forever
                if (start_hit) begin
                    n.fire     = 1'b0;
                    n.st       = S_COUNT;
                    n.cnt      = 16'h0000;
                    n.stop_idx = 3'h0;
                    n.ovf_hit  = 1'b0;
                    n.regs[A_INTERVAL_FIRST[4:0]] = fine_code;
                end
            end
            S_COUNT: begin
                n.cnt = q.cnt + 16'h0001;
                if (q.cnt >= limit) begin
                    n.ovf_hit = 1'b1;
                    if (mode2) begin
                        set_fl[F_TICK_OVF] = 1'b1;
                    end else begin
                        set_fl[F_COARSE_OVF] = 1'b1;
                    end
                    n.st = setup1[B_FORCE_CAL] ? S_CAL1 : S_END;
                end else if (stop_hit && q.cnt >= blank) begin
                    n.regs[time_idx]  = fine_code;
                    n.regs[tally_idx] = q.regs[tally_idx] + {8'h00, q.cnt};
                    n.stop_idx        = q.stop_idx + 3'h1;
                    if (q.stop_idx + 3'h1 == stops) begin
                        n.st = S_CAL1;
                    end
                end
            end
            S_CAL1: begin
                n.regs[A_CAL_SINGLE[4:0]] = fine_code;
                n.cal_cnt = 6'h00;
                n.st      = S_CAL2;
            end
            S_CAL2: begin
                n.cal_cnt = q.cal_cnt + 6'h01;
                if (q.cal_cnt == cal_len - 6'h01) begin
                    n.regs[A_CAL_MULTI[4:0]] = fine_code;
                    n.st = S_END;
                end
            end
            S_END: begin
                // an overflow ends the whole series at once
                if (!q.ovf_hit && q.avg_idx + 8'h01 < avg_total) begin
                    n.avg_idx = q.avg_idx + 8'h01;
                    n.fire    = 1'b1;
                    n.st      = S_ARM;
                end else begin
                    set_fl[F_DONE] = ~q.ovf_hit;
                    n.regs[A_FIRST_SETUP[4:0]][B_GO] = 1'b0;
                    n.st = S_IDLE;
                end
            end
            default: begin
                n.st   = S_IDLE;
                n.fire = 1'b0;
            end
        endcase

        // host write lands after the sequencer so a fresh go bit survives
        if (sy[SY_SEL]) begin
            n.tgl_prev = 1'b0;
        end else if (sy[SY_TGL] != q.tgl_prev) begin
            n.tgl_prev = sy[SY_TGL];
            if (bus.wr_addr == A_EVENT_FLAGS) begin
                clr_fl = bus.wr_data;
            end else begin
                n.regs[bus.wr_addr[4:0]] = {16'h0000, bus.wr_data};
            end
        end

        // write-one-to-clear, a new event in the same cycle wins
        flags = (q.regs[A_EVENT_FLAGS[4:0]][7:0] & ~clr_fl) | set_fl;
        n.regs[A_EVENT_FLAGS[4:0]] = {16'h0000, flags};
        n.irq_n    = ~|(flags & n.regs[A_EVENT_ENABLE[4:0]][7:0]);
        n.fire_pin = n.fire ^ n.regs[A_FIRST_SETUP[4:0]][B_FIRE_LOW];

        // readback copy only moves while no frame is open
        if (sy[SY_SEL]) begin
            n.bank = q.regs;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            q <= core_reset();
        end else if (ce) begin
            q <= n;
        end
    end

    assign bus.rd_bank = q.bank;
    assign fire_out    = q.fire_pin;
    assign done_irq_n  = q.irq_n;
endmodule : tof_measurement_sequencer
`default_nettype wire

//--- include/reg_link_if.sv
// register traffic between the serial port and the sequencer core
`timescale 1ns/100ps
`default_nettype none
interface reg_link_if;
    import tof_pkg::*;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic       wr_tgl;
    reg_bank_t  rd_bank;
    modport link (output wr_addr, output wr_data, output wr_tgl, input rd_bank);
    modport core (input wr_addr, input wr_data, input wr_tgl, output rd_bank);
endinterface : reg_link_if
`default_nettype wire

//--- include/tof_pkg.sv
// shared constants, types and helpers of the time-of-flight sequencer
// Notes on behaviour
// - no start waits forever; start without stop ends in counter overflow and interrupt.
// - several stops: time to the last stop, each earlier stop captured separately.
// - a setup field picks one to five stops per measurement.
// - averaging runs the whole series alone, interrupt only after the last cycle.
// - averaging count field selects 1 to 128 cycles; host sets it first.
// - after each cycle's calibration either fire again or raise the interrupt.
// - go bit drives the fire output, then start input is armed.
// - fire output returns inactive once the start edge arrives.
// - second mode counts from the first clock edge after start; stops masked.
// - stop input only listens once the counter reached the blanking value.
// - after the last stop interrupt and pins off, or next averaging cycle fires.
// - setting go again starts a new measurement with kept settings.
// - enable low discards all settings; registers return to defaults.
// - write is command plus data byte; read is command plus 8 or 24 bits.
// - command byte holds auto-increment flag, write flag and six-bit address.
// - select stays low per transaction; release aborts, low again readies.
// - serial data output driven only during reads, released otherwise.
// - bit 7 auto-increment, bit 6 write when set, low six bits address.
// - input sampled on rising shift clock, msb first, register loaded on last bit.
// - auto-increment walks on to following registers; otherwise extra bits ignored.
`default_nettype none
package tof_pkg;
    localparam int         REG_NUM          = 29;
    localparam int         BYTE_BITS        = 8;
    localparam int         WORD_BITS        = 24;
    localparam logic [5:0] A_FIRST_SETUP    = 6'h00;
    localparam logic [5:0] A_SECOND_SETUP   = 6'h01;
    localparam logic [5:0] A_EVENT_FLAGS    = 6'h02;
    localparam logic [5:0] A_EVENT_ENABLE   = 6'h03;
    localparam logic [5:0] A_COARSE_LIMIT_H = 6'h04;
    localparam logic [5:0] A_COARSE_LIMIT_L = 6'h05;
    localparam logic [5:0] A_TICK_LIMIT_H   = 6'h06;
    localparam logic [5:0] A_TICK_LIMIT_L   = 6'h07;
    localparam logic [5:0] A_ECHO_BLANK_H   = 6'h08;
    localparam logic [5:0] A_ECHO_BLANK_L   = 6'h09;
    localparam logic [5:0] A_INTERVAL_FIRST = 6'h10;
    localparam logic [5:0] A_CYCLE_TALLY    = 6'h11;
    localparam logic [5:0] A_CAL_SINGLE     = 6'h1B;
    localparam logic [5:0] A_CAL_MULTI      = 6'h1C;
    localparam logic [7:0] RST_SECOND_SETUP = 8'h40;
    localparam logic [7:0] RST_EVENT_ENABLE = 8'h07;
    localparam logic [7:0] RST_LIMIT        = 8'hFF;
    localparam int         B_GO             = 0;
    localparam int         B_MODE           = 1;
    localparam int         B_START_FALL     = 3;
    localparam int         B_STOP_FALL      = 4;
    localparam int         B_FIRE_LOW       = 5;
    localparam int         B_FORCE_CAL      = 7;
    localparam logic [1:0] MODE_SECOND      = 2'h1;
    localparam int         B_STOPS          = 0;
    localparam int         B_AVG            = 3;
    localparam int         B_CALP           = 6;
    localparam logic [2:0] MAX_STOPS        = 3'h5;
    localparam int         F_DONE           = 0;
    localparam int         F_COARSE_OVF     = 1;
    localparam int         F_TICK_OVF       = 2;
    localparam int         CMD_AUTO         = 7;
    localparam int         CMD_WRITE        = 6;
    localparam logic [3:0][5:0] CAL_PERIODS = {6'h28, 6'h14, 6'h0A, 6'h02};
    localparam int         SY_EN            = 0;
    localparam int         SY_START         = 1;
    localparam int         SY_STOP          = 2;
    localparam int         SY_SEL           = 3;
    localparam int         SY_TGL           = 4;
    localparam int         SY_W             = 5;
    localparam logic [4:0] SYNC_RST         = 5'h08;

    typedef logic [REG_NUM-1:0][23:0] reg_bank_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_ARM   = 3'b001,
        S_COUNT = 3'b010,
        S_CAL1  = 3'b011,
        S_CAL2  = 3'b100,
        S_END   = 3'b101
    } seq_state_e;

    function automatic logic [4:0] reg_len(input logic [5:0] a);
        return (a >= A_INTERVAL_FIRST) ? 5'(WORD_BITS) : 5'(BYTE_BITS);
    endfunction : reg_len

    function automatic logic edge_hit(input logic prev, input logic cur, input logic fall);
        return fall ? (prev & ~cur) : (~prev & cur);
    endfunction : edge_hit
endpackage : tof_pkg
`default_nettype wire

//--- sim/spi_host_model.sv
// serial host framing register traffic on its own clock
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    output var  logic sclk,
    output var  logic select_n,
    output var  logic sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe_n
);
    logic line_prev;
    initial begin
        sclk = 1'b0;
        select_n = 1'b1;
        sdi = 1'b0;
        line_prev = 1'b0;
    end
    // clock stands still outside frames
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd, output logic [23:0] rd);
        logic [31:0] sh;
        logic        bit_v;
        sh = {cmd, wd << (24 - n)};
        rd = 24'h000000;
        #3 select_n = 1'b0;
        for (int i = 0; i < 8 + n; i++) begin
            sdi = sh[31 - i];
            #80;
            // released line: never let a stale level pass
            bit_v = sdo_oe_n ? ~line_prev : sdo;
            line_prev = bit_v;
            if (i >= 8) rd = {rd[22:0], bit_v};
            sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #80 select_n = 1'b1;
        #120;
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

//--- sim/tof_measurement_sequencer_tb.sv
// self-checking bench of the measurement sequencer
`timescale 1ns/100ps
`default_nettype none
module tof_measurement_sequencer_tb;
    import tof_pkg::*;
    logic ref_clk, rst, ce, enable, start_in, stop_in;
    logic [23:0] fine_code;
    wire logic sclk, select_n, sdi, sdo, sdo_oe_n, fire_out, done_irq_n;
    int n_errors, check_count;
    tof_measurement_sequencer u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .enable(enable),
        .sclk(sclk), .select_n(select_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .start_in(start_in), .stop_in(stop_in), .fine_code(fine_code), .fire_out(fire_out),
        .done_irq_n(done_irq_n));
    spi_host_model u_host (.sclk(sclk), .select_n(select_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        logic [23:0] r;
        u_host.xfer({2'b01, a}, 8, {16'h0000, d}, r);
        repeat (6) @(posedge ref_clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [5:0] a, input int n, input logic ai, output logic [23:0] v);
        u_host.xfer({ai, 1'b0, a}, n, 24'h000000, v);
    endtask : rd_reg
    task automatic wait_pin(input logic is_irq, input logic lvl, input int lim);
        int k;
        k = 0;
        while (((is_irq ? done_irq_n : fire_out) !== lvl) && k < lim) begin
            @(negedge ref_clk);
            k++;
        end
        check("pin wait", {23'h0, k < lim}, 24'h000001);
    endtask : wait_pin
    // equal rising polarity on both pins
    task automatic pulse(input logic stop);
        @(posedge ref_clk);
        if (stop) stop_in <= 1'b1;
        else start_in <= 1'b1;
        repeat (3) @(posedge ref_clk);
        stop_in <= 1'b0;
        start_in <= 1'b0;
    endtask : pulse
    task automatic t_defaults;
        logic [5:0]  ad [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07, 6'h09, 6'h0A};
        logic [7:0]  ex [8] = '{8'h00, 8'h40, 8'h00, 8'h07, 8'hFF, 8'hFF, 8'h00, 8'h00};
        logic [23:0] v;
        for (int i = 0; i < 8; i++) begin
            rd_reg(ad[i], 8, 1'b0, v);
            check("default", v, {16'h0000, ex[i]});
        end
    endtask : t_defaults
    task automatic t_port;
        logic [23:0] v;
        wr_reg(A_ECHO_BLANK_L, 8'h08);
        rd_reg(A_ECHO_BLANK_H, 16, 1'b1, v);
        check("auto read", v, 24'h000008);
        rd_reg(A_ECHO_BLANK_L, 16, 1'b0, v);
        check("long read", v, 24'h000800);
        u_host.xfer({2'b01, A_ECHO_BLANK_L}, 4, 24'h00000F, v);
        repeat (6) @(posedge ref_clk);
        rd_reg(A_ECHO_BLANK_L, 8, 1'b0, v);
        check("aborted write", v, 24'h000008);
    endtask : t_port
    // mode two, one stop; an early stop falls inside the blanking
    task automatic t_single;
        logic [23:0] v;
        wr_reg(A_SECOND_SETUP, 8'h00);
        wr_reg(A_FIRST_SETUP, 8'h03);
        wait_pin(1'b0, 1'b1, 10);
        repeat (40) @(negedge ref_clk);
        check("fire waits", {23'h0, fire_out}, 24'h000001);
        pulse(1'b0);
        pulse(1'b1);
        repeat (20) @(negedge ref_clk);
        check("masked stop", {23'h0, done_irq_n}, 24'h000001);
        check("fire after start", {23'h0, fire_out}, 24'h000000);
        pulse(1'b1);
        wait_pin(1'b1, 1'b0, 30);
        rd_reg(A_CYCLE_TALLY, 24, 1'b0, v);
        check("tally", {23'h0, v >= 24'd25 && v <= 24'd27}, 24'h000001);
        rd_reg(6'h12, 24, 1'b0, v);
        check("stop fine", v, 24'h00ABCD);
        wr_reg(A_EVENT_FLAGS, 8'h01);
        check("irq cleared", {23'h0, done_irq_n}, 24'h000001);
    endtask : t_single
    // two stops, two cycles, started again with kept blanking
    task automatic t_avg;
        logic [23:0] v;
        wr_reg(A_SECOND_SETUP, 8'h09);
        wr_reg(A_FIRST_SETUP, 8'h03);
        for (int c = 0; c < 2; c++) begin
            wait_pin(1'b0, 1'b1, 30);
            check("irq mid series", {23'h0, done_irq_n}, 24'h000001);
            pulse(1'b0);
            repeat (12) @(posedge ref_clk);
            pulse(1'b1);
            repeat (6) @(posedge ref_clk);
            pulse(1'b1);
        end
        wait_pin(1'b1, 1'b0, 30);
        rd_reg(A_CYCLE_TALLY, 24, 1'b0, v);
        check("tally 1", {23'h0, (v >> 1) >= 24'd15 && (v >> 1) <= 24'd17}, 24'h000001);
        rd_reg(6'h13, 24, 1'b0, v);
        check("tally 2", {23'h0, (v >> 1) >= 24'd25 && (v >> 1) <= 24'd27}, 24'h000001);
        wr_reg(A_EVENT_FLAGS, 8'h01);
    endtask : t_avg
    task automatic t_ovf;
        logic [23:0] v;
        wr_reg(A_SECOND_SETUP, 8'h00);
        wr_reg(A_TICK_LIMIT_H, 8'h00);
        wr_reg(A_TICK_LIMIT_L, 8'h20);
        wr_reg(A_FIRST_SETUP, 8'h03);
        wait_pin(1'b0, 1'b1, 10);
        pulse(1'b0);
        wait_pin(1'b1, 1'b0, 80);
        rd_reg(A_EVENT_FLAGS, 8, 1'b0, v);
        check("overflow flag", v, 24'h000004);
        wr_reg(A_EVENT_FLAGS, 8'h04);
        check("irq cleared", {23'h0, done_irq_n}, 24'h000001);
        // mode one on the coarse limit, calibration forced after the overflow
        wr_reg(A_COARSE_LIMIT_H, 8'h00);
        wr_reg(A_COARSE_LIMIT_L, 8'h20);
        wr_reg(A_FIRST_SETUP, 8'h81);
        pulse(1'b0);
        wait_pin(1'b1, 1'b0, 80);
        rd_reg(A_EVENT_FLAGS, 8, 1'b0, v);
        check("coarse flag", v, 24'h000002);
        wr_reg(A_EVENT_FLAGS, 8'h02);
    endtask : t_ovf
    task automatic t_enable;
        logic [23:0] v;
        @(posedge ref_clk) enable <= 1'b0;
        repeat (5) @(posedge ref_clk);
        enable <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rd_reg(A_SECOND_SETUP, 8, 1'b0, v);
        check("setup after enable", v, 24'h000040);
        rd_reg(A_TICK_LIMIT_L, 8, 1'b0, v);
        check("limit after enable", v, 24'h0000FF);
    endtask : t_enable
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        finish_test();
    end
    initial begin
        {rst, ce, enable, start_in, stop_in} = 5'b11000;
        fine_code = 24'h00ABCD;
        n_errors = 0;
        check_count = 0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        enable <= 1'b1;
        // settle wait after enable kept short so the run stays brief
        repeat (10) @(posedge ref_clk);
        t_defaults();
        t_port();
        t_single();
        t_avg();
        t_ovf();
        t_enable();
        finish_test();
    end
endmodule : tof_measurement_sequencer_tb
`default_nettype wire

//--- sim/tof_sequencer_asserts.sv
// pin level checks of the measurement sequencer
`timescale 1ns/100ps
`default_nettype none
module tof_sequencer_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic sclk,
    input wire logic select_n,
    input wire logic sdi,
    input wire logic sdo_oe_n,
    input wire logic start_in,
    input wire logic fire_out,
    input wire logic done_irq_n
);
    logic [5:0] edge_cnt_q;
    // shift edges of the frame; select high clears at once
    always_ff @(posedge sclk or posedge select_n) begin
        if (select_n) begin
            edge_cnt_q <= 6'h00;
        end else if (edge_cnt_q != 6'h3F) begin
            edge_cnt_q <= edge_cnt_q + 6'h01;
        end
    end
    // two sync stages sit between pin and core
    property p_fire_drop;
        @(posedge ref_clk) disable iff (rst) $rose(start_in) && fire_out |-> ##[1:8] !fire_out;
    endproperty
    a_fire_drop: assert property (p_fire_drop) else $error("fire kept after start");
    property p_fire_wait;
        @(posedge ref_clk) disable iff (rst) fire_out && enable && !start_in && !$past(start_in)
            && !$past(start_in, 2) && !$past(start_in, 3) |=> fire_out;
    endproperty
    a_fire_wait: assert property (p_fire_wait) else $error("fire lost without start");
    property p_irq_quiet;
        @(posedge ref_clk) disable iff (rst) !done_irq_n |-> !fire_out;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("fire during irq");
    property p_irq_holds;
        @(posedge ref_clk) disable iff (rst) !done_irq_n && enable && select_n && $past(select_n, 8)
            |=> !done_irq_n;
    endproperty
    a_irq_holds: assert property (p_irq_holds) else $error("irq dropped alone");
    property p_en_low;
        @(posedge ref_clk) disable iff (rst) !enable [*3] |=> !fire_out && done_irq_n;
    endproperty
    a_en_low: assert property (p_en_low) else $error("pins active while disabled");
    property p_oe_sel;
        @(posedge ref_clk) disable iff (rst) select_n |-> sdo_oe_n;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("sdo driven unselected");
    property p_oe_count;
        @(posedge sclk) disable iff (rst) $fell(sdo_oe_n) |-> !select_n && edge_cnt_q == 6'h08;
    endproperty
    a_oe_count: assert property (p_oe_count) else $error("sdo driven off command end");
    property p_oe_read;
        @(posedge sclk) disable iff (rst) $fell(sdo_oe_n) |-> !$past(sdi, 7);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("sdo driven in write");
endmodule : tof_sequencer_asserts
bind tof_measurement_sequencer tof_sequencer_asserts u_chk (.ref_clk, .rst, .enable, .sclk, .select_n,
    .sdi, .sdo_oe_n, .start_in, .fire_out, .done_irq_n);
`default_nettype wire
